// File: hw/hcpd_pkg.sv
/*
 * Shared constants, types and check-code functions for the header check
 * and packet delineation block.
 * Assumes octet-serial data, least significant bit first into the check code.
 */
package hcpd_pkg;

    // widths and sizes
    localparam int OCT_W       = 8;
    localparam int WORD_W      = 32;
    localparam int CTRL_W      = 4;
    localparam int HDR_OCTETS  = 8;
    localparam int WIN_OCTETS  = 10;
    localparam int LEN_W       = 16;
    localparam int GAP_W       = 17;
    localparam int FIFO_DEPTH  = 16;
    localparam int FIFO_W      = 9;
    localparam int SCR_LEN     = 43;
    localparam int IDLE_OCTETS = 9;
    localparam int CONFIRM_DEF = 1;

    // check code
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] HEC_MASK = 16'h1555;
    // remainder of x^16 modulo the generator, start of the syndrome walk
    localparam logic [15:0] X16_REM  = 16'h1021;

    // octet values
    localparam logic [7:0]  SFD_IDLE   = 8'h00;
    localparam logic [7:0]  NULL_CHAR  = 8'h07;
    localparam logic [7:0]  FILL_OCTET = 8'h00;
    localparam logic [71:0] IDLE_SEQ   = 72'h00_00_55_55_55_55_00_2A_01;

    // receive framing
    localparam logic [16:0] GAP_ADJ   = 17'h00009;
    localparam logic [3:0]  CTRL_DATA = 4'h0;
    localparam logic [3:0]  CTRL_NULL = 4'hF;
    localparam logic [1:0]  PRE_WORDS = 2'h2;

    typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_HEC, TX_BODY} hcpd_tx_state_type;
    typedef enum logic [1:0] {SEARCH_STATE, TENTATIVE_LOCK_STATE, LOCKED_STATE}
        hcpd_rx_state_type;

    // one octet into the check code, lowest bit first
    function automatic logic [15:0] hcpd_crc_octet(input logic [15:0] crc,
                                                   input logic [7:0]  d);
        logic [15:0] c;
        logic        fb;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            fb = c[15] ^ d[i];
            c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : hcpd_crc_octet

    // check field over eight octets, octet n at bits [8n+7:8n]
    function automatic logic [15:0] hcpd_hec_of(input logic [63:0] w);
        logic [15:0] c;
        c = CRC_INIT;
        for (int n = 0; n < HDR_OCTETS; n++) begin
            c = hcpd_crc_octet(c, w[8*n +: 8]);
        end
        return c ^ HEC_MASK;
    endfunction : hcpd_hec_of

    function automatic logic [7:0] hcpd_rev8(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
        end
        return r;
    endfunction : hcpd_rev8

endpackage : hcpd_pkg

// File: hw/hcpd_stream_if.sv
/*
 * Valid/ready stream carrier between the block's own modules.
 * Assumes a transfer happens on a clock edge with valid and ready both high.
 */
interface hcpd_stream_if #(
    parameter int W = 9
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : hcpd_stream_if

// File: hw/hcpd_fifo.sv
/*
 * Synchronous first-in first-out buffer with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
module hcpd_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // streams
    hcpd_stream_if.snk s_in,
    hcpd_stream_if.src s_out
);
    import hcpd_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } hcpd_fifo_st_type;

    hcpd_fifo_st_type st_r;
    hcpd_fifo_st_type st_nxt;
    logic             full;
    logic             empty;

    // extra pointer bit tells a full buffer from an empty one
    assign empty = (st_r.wp == st_r.rp);
    assign full  = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);

    assign s_in.ready  = !full;
    assign s_out.valid = !empty;
    assign s_out.data  = st_r.mem[st_r.rp[AW-1:0]];

    always_comb begin
        st_nxt = st_r;
        if (s_in.valid && !full) begin
            st_nxt.mem[st_r.wp[AW-1:0]] = s_in.data;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (s_out.ready && !empty) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : hcpd_fifo

// File: hw/hcpd_scrambler.sv
/*
 * Self-synchronous x^43+1 scrambler or descrambler, one octet per enable,
 * lowest bit first. Output is combinational from the current state.
 * Assumes the caller enables it only for octets that are to be processed;
 * while disabled the state is kept.
 */
module hcpd_scrambler #(
    parameter bit DESCRAMBLE = 1'b0
) (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // octet path
    input  wire logic       i_en,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data
);
    import hcpd_pkg::*;

    typedef struct packed {
        logic [SCR_LEN-1:0] sr;
    } hcpd_scr_st_type;

    hcpd_scr_st_type st_r;
    hcpd_scr_st_type st_nxt;

    always_comb begin
        logic [SCR_LEN-1:0] s;
        logic               b;
        s      = st_r.sr;
        b      = 1'b0;
        o_data = 8'h00;
        for (int i = 0; i < 8; i++) begin
            b         = i_data[i] ^ s[SCR_LEN-1];
            o_data[i] = b;
            // descrambler shifts in the line bit, scrambler its own output
            s = {s[SCR_LEN-2:0], DESCRAMBLE ? i_data[i] : b};
        end
        st_nxt = st_r;
        if (i_en) begin
            st_nxt.sr = s;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : hcpd_scrambler

// File: hw/hcpd_top.sv
/*
 * Header check generation, header check validation and packet delineation.
 * Transmit: buffers MAC octets (preamble and SFD first), inserts the check
 * field, scrambles the rest and fills gaps with idle packets.
 * Receive: finds packet starts from the check field and length field and
 * hands 32-bit words with lane control flags toward the MAC.
 * Assumes the attachment layer paces both directions with its strobes and
 * that all inputs are synchronous to i_sys_clk.
 */
// Summary of operation
// R1 - each received octet: check last ten, first eight must yield the final two
// R2 - sent check field is the CRC-16 of eight header octets xor fixed mask
// R3 - CRC-16 generator has terms x^16, x^12, x^5 and 1
// R4 - header octets enter the CRC in order, each lowest bit first
// R5 - result is remainder of message times x^16, x^15 term as top bit
// R6 - check octets are bit-reversed within each octet when placed in stream
// R7 - check octets follow the SFD; every later packet octet is scrambled
// R8 - first two header octets carry the DA-through-FCS length
// R9 - search tests every octet; first correct check enters tentative lock
// R10 - tentative lock tests only expected starts; confirm count locks, error searches
// R11 - next expected start is found from the current packet's length field
// R12 - locked: uncorrectable error searches; correct or corrected check marks a start
// R13 - idle packets only aid delineation, never flagged, otherwise dropped
// R14 - confirm count is a parameter, default one
// R15 - with no MAC packet waiting the transmitter sends an idle packet
// R16 - an all-zero SFD marks a packet as idle
// R17 - idle packet is the fixed nine-octet sequence
// R18 - receive octets are taken only while the valid strobe is high
// R19 - transmit octet is held until taken with the accept strobe high
// R20 - entering the locked state selects single-bit correction mode
// R21 - descrambler runs only when locked, between check field and packet end
// R22 - the two check octets are never passed toward the MAC
// R23 - without a full word, a word of null control characters is output
// R24 - a corrected error switches to detection; next correct check restores correction
// R25 - reset starts in search with confirm counter cleared, no start flagged
module hcpd_top #(
    parameter logic [7:0] CONFIRM_COUNT = 8'(hcpd_pkg::CONFIRM_DEF),
    parameter int         FIFO_DEPTH    = hcpd_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_rst,
    // mac transmit octets
    input  wire logic                           i_tx_valid,
    input  wire logic [hcpd_pkg::OCT_W-1:0]     i_tx_data,
    input  wire logic                           i_tx_last,
    output logic                                o_tx_ready,
    // attachment layer transmit
    output logic      [hcpd_pkg::OCT_W-1:0]     o_tx_octet,
    input  wire logic                           i_tx_octet_rdy,
    // attachment layer receive
    input  wire logic [hcpd_pkg::OCT_W-1:0]     i_rx_octet,
    input  wire logic                           i_rx_octet_en,
    // mac receive words and status
    output logic      [hcpd_pkg::WORD_W-1:0]    o_rx_word,
    output logic      [hcpd_pkg::CTRL_W-1:0]    o_rx_ctrl,
    output logic                                o_rx_start,
    output logic                                o_rx_locked
);
    import hcpd_pkg::*;

    typedef struct packed {
        // transmit
        hcpd_tx_state_type  txs;
        logic [3:0]         tx_cnt;
        logic [7:0]         tx_octet;
        logic [15:0]        crc;
        logic               tx_last;
        // receive delineation
        hcpd_rx_state_type  rxs;
        logic [79:0]        win;
        logic [GAP_W-1:0]   gap;
        logic [LEN_W-1:0]   body;
        logic               corr_mode;
        logic [7:0]         conf;
        // receive word output
        logic [63:0]        pre;
        logic [1:0]         pre_cnt;
        logic [31:0]        pk;
        logic [2:0]         pk_cnt;
        logic               flush;
        logic [31:0]        word;
        logic [3:0]         ctrl;
        logic               start;
    } hcpd_st_type;

    hcpd_st_type st_r;
    hcpd_st_type st_nxt;

    hcpd_stream_if #(.W(FIFO_W)) tx_in ();
    hcpd_stream_if #(.W(FIFO_W)) tx_out ();

    logic [7:0]  scr_in;
    logic [7:0]  scr_out;
    logic        scr_en;
    logic [7:0]  dscr_out;
    logic        in_body;

    // check evaluation on the window as it stands once the new octet is in
    logic [79:0] win_sh;
    logic [63:0] hdr_raw;
    logic [63:0] hdr_fix;
    logic [63:0] flip;
    logic [15:0] hec_calc;
    logic [15:0] hec_rx;
    logic [15:0] syn;
    logic        chk_ok;
    logic        chk_single;
    logic [LEN_W-1:0] len_fix;
    logic        is_idle;

    // mac octets pass through the buffer so short gaps do not starve a packet
    assign tx_in.valid = i_tx_valid;
    assign tx_in.data  = {i_tx_last, i_tx_data};
    assign o_tx_ready  = tx_in.ready;

    hcpd_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .s_in      (tx_in),
        .s_out     (tx_out)
    );

    hcpd_scrambler #(
        .DESCRAMBLE (1'b0)
    ) u_tx_scr (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_en      (scr_en),
        .i_data    (scr_in),
        .o_data    (scr_out)
    );

    assign in_body = (st_r.rxs == LOCKED_STATE) && (st_r.body != '0);

    hcpd_scrambler #(
        .DESCRAMBLE (1'b1)
    ) u_rx_dscr (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_en      (i_rx_octet_en && in_body),  // [R21]
        .i_data    (i_rx_octet),
        .o_data    (dscr_out)
    );

    // header check and single-bit syndrome search
    always_comb begin
        logic [15:0] p;
        p          = X16_REM;
        win_sh     = {i_rx_octet, st_r.win[79:8]};
        hdr_raw    = win_sh[63:0];
        hec_calc   = hcpd_hec_of(hdr_raw);  // [R2] [R3] [R4] [R5]
        hec_rx     = {hcpd_rev8(win_sh[71:64]), hcpd_rev8(win_sh[79:72])};
        syn        = hec_calc ^ hec_rx;
        chk_ok     = (syn == 16'h0000);  // [R1]
        chk_single = $onehot(syn);
        flip       = '0;
        // a flipped header bit of degree k leaves syndrome x^(k+16) mod G
        for (int k = 0; k < 64; k++) begin
            if (!chk_ok && syn == p) begin
                flip[63-k] = 1'b1;
                chk_single = 1'b1;
            end
            p = {p[14:0], 1'b0} ^ (p[15] ? CRC_POLY : 16'h0000);
        end
        hdr_fix = hdr_raw ^ flip;
        len_fix = {hdr_fix[7:0], hdr_fix[15:8]};  // [R8]
        is_idle = (hdr_fix[63:56] == SFD_IDLE);  // [R16]
    end

    always_comb begin
        logic        take;
        logic        boundary;
        logic        chk_here;
        logic        valid_start;
        logic        emit;
        logic [2:0]  base;
        logic [15:0] hec_tx;
        logic [7:0]  next_conf;

        st_nxt      = st_r;
        st_nxt.start = 1'b0;
        take        = 1'b0;
        scr_en      = 1'b0;
        scr_in      = FILL_OCTET;
        valid_start = 1'b0;
        hec_tx      = st_r.crc ^ HEC_MASK;  // [R2]
        next_conf   = st_r.conf + 8'h01;
        boundary    = ((st_r.txs == TX_IDLE) && (st_r.tx_cnt == 4'(IDLE_OCTETS - 1))) ||
                      ((st_r.txs == TX_BODY) && st_r.tx_last);
        emit = (st_r.pre_cnt == 2'h0) &&
               ((st_r.pk_cnt == 3'h4) || (st_r.flush && st_r.pk_cnt != 3'h0));
        base = emit ? 3'h0 : st_r.pk_cnt;
        chk_here = (st_r.rxs == SEARCH_STATE) || (st_r.gap == '0);  // [R9] [R10]

        // transmit: the octet on the bus changes only once it has been taken
        if (i_tx_octet_rdy) begin  // [R19]
            if (boundary) begin
                if (tx_out.valid) begin
                    take           = 1'b1;
                    st_nxt.txs     = TX_HDR;
                    st_nxt.tx_cnt  = 4'h0;
                    st_nxt.tx_octet = tx_out.data[7:0];
                    st_nxt.crc     = hcpd_crc_octet(CRC_INIT, tx_out.data[7:0]);  // [R4]
                end else begin
                    st_nxt.txs     = TX_IDLE;  // [R15]
                    st_nxt.tx_cnt  = 4'h0;
                    st_nxt.tx_octet = IDLE_SEQ[71 -: 8];  // [R17]
                end
            end else begin
                case (st_r.txs)
                    TX_IDLE: begin
                        st_nxt.tx_cnt   = st_r.tx_cnt + 4'h1;
                        st_nxt.tx_octet = IDLE_SEQ[71 - 8*st_nxt.tx_cnt -: 8];  // [R17]
                    end
                    TX_HDR: begin
                        if (st_r.tx_cnt == 4'(HDR_OCTETS - 1)) begin
                            // check field right after the SFD, bit-reversed
                            st_nxt.txs      = TX_HEC;  // [R7]
                            st_nxt.tx_cnt   = 4'h0;
                            st_nxt.tx_octet = hcpd_rev8(hec_tx[15:8]);  // [R6]
                        end else begin
                            // an empty buffer mid-header sends filler, and the check is computed over the filler
                            take            = tx_out.valid;
                            st_nxt.tx_cnt   = st_r.tx_cnt + 4'h1;
                            st_nxt.tx_octet = tx_out.valid ? tx_out.data[7:0] : FILL_OCTET;
                            st_nxt.crc      = hcpd_crc_octet(st_r.crc, st_nxt.tx_octet);
                        end
                    end
                    TX_HEC: begin
                        if (st_r.tx_cnt == 4'h0) begin
                            st_nxt.tx_cnt   = 4'h1;
                            st_nxt.tx_octet = hcpd_rev8(hec_tx[7:0]);  // [R6]
                        end else begin
                            take            = tx_out.valid;
                            scr_en          = 1'b1;
                            scr_in          = tx_out.valid ? tx_out.data[7:0] : FILL_OCTET;
                            st_nxt.txs      = TX_BODY;
                            st_nxt.tx_octet = scr_out;  // [R7]
                            st_nxt.tx_last  = tx_out.valid && tx_out.data[8];
                        end
                    end
                    TX_BODY: begin
                        take            = tx_out.valid;
                        scr_en          = 1'b1;
                        scr_in          = tx_out.valid ? tx_out.data[7:0] : FILL_OCTET;
                        st_nxt.tx_octet = scr_out;  // [R7]
                        st_nxt.tx_last  = tx_out.valid && tx_out.data[8];
                    end
                    default: begin
                        st_nxt.txs = TX_IDLE;
                    end
                endcase
            end
        end
        tx_out.ready = take;

        // receive word output: preamble words first, then packed body octets
        if (st_r.pre_cnt != 2'h0) begin
            st_nxt.word    = (st_r.pre_cnt == PRE_WORDS) ? st_r.pre[31:0] : st_r.pre[63:32];
            st_nxt.ctrl    = CTRL_DATA;
            st_nxt.pre_cnt = st_r.pre_cnt - 2'h1;
        end else if (emit) begin
            for (int l = 0; l < 4; l++) begin
                st_nxt.word[8*l +: 8] = (3'(l) < st_r.pk_cnt) ? st_r.pk[8*l +: 8] : NULL_CHAR;
                st_nxt.ctrl[l]        = (3'(l) >= st_r.pk_cnt);
            end
            st_nxt.pk_cnt = 3'h0;
            st_nxt.flush  = 1'b0;
        end else begin
            st_nxt.word = {4{NULL_CHAR}};  // [R23]
            st_nxt.ctrl = CTRL_NULL;
            if (st_r.pk_cnt == 3'h0) begin
                st_nxt.flush = 1'b0;
            end
        end
        if (emit) begin
            st_nxt.pk_cnt = 3'h0;
        end

        // receive delineation, only on octets the attachment layer marks valid
        if (i_rx_octet_en) begin  // [R18]
            st_nxt.win = win_sh;
            if (in_body) begin
                // body octets go out descrambled; check octets never reach here
                st_nxt.pk[8*base[1:0] +: 8] = dscr_out;  // [R21] [R22]
                st_nxt.pk_cnt               = base + 3'h1;
                st_nxt.body                 = st_r.body - 16'h0001;
                if (st_r.body == 16'h0001) begin
                    st_nxt.flush = 1'b1;
                end
            end
            if (!chk_here) begin
                st_nxt.gap = st_r.gap - 17'h00001;
            end else begin
                case (st_r.rxs)
                    SEARCH_STATE: begin
                        if (chk_ok) begin
                            st_nxt.rxs  = TENTATIVE_LOCK_STATE;  // [R9]
                            st_nxt.conf = 8'h00;
                            st_nxt.gap  = 17'(len_fix) + GAP_ADJ;  // [R11]
                        end
                    end
                    TENTATIVE_LOCK_STATE: begin
                        if (chk_ok) begin
                            st_nxt.gap = 17'(len_fix) + GAP_ADJ;  // [R11]
                            if (next_conf >= CONFIRM_COUNT) begin  // [R14]
                                st_nxt.rxs       = LOCKED_STATE;  // [R10]
                                st_nxt.corr_mode = 1'b1;  // [R20]
                                st_nxt.conf      = 8'h00;
                            end else begin
                                st_nxt.conf = next_conf;
                            end
                        end else begin
                            st_nxt.rxs  = SEARCH_STATE;  // [R10]
                            st_nxt.conf = 8'h00;
                        end
                    end
                    LOCKED_STATE: begin
                        if (chk_ok) begin
                            valid_start      = 1'b1;
                            st_nxt.corr_mode = 1'b1;  // [R24]
                        end else if (chk_single && st_r.corr_mode) begin
                            valid_start      = 1'b1;  // [R12]
                            st_nxt.corr_mode = 1'b0;  // [R24]
                        end else begin
                            st_nxt.rxs  = SEARCH_STATE;  // [R12]
                            st_nxt.conf = 8'h00;
                            st_nxt.body = '0;
                        end
                    end
                    default: begin
                        st_nxt.rxs = SEARCH_STATE;
                    end
                endcase
                if (valid_start) begin
                    st_nxt.gap = 17'(len_fix) + GAP_ADJ;  // [R11]
                    // idle packets keep the framing but produce nothing else
                    if (!is_idle) begin  // [R13]
                        st_nxt.start   = 1'b1;  // [R12]
                        st_nxt.body    = len_fix;
                        st_nxt.pre     = hdr_fix;
                        st_nxt.pre_cnt = PRE_WORDS;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            // all zero: search, idle octet 0 on the bus, no start flagged
            st_r <= '0;  // [R25]
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_tx_octet  = st_r.tx_octet;
    assign o_rx_word   = st_r.word;
    assign o_rx_ctrl   = st_r.ctrl;
    assign o_rx_start  = st_r.start;
    assign o_rx_locked = (st_r.rxs == LOCKED_STATE);

endmodule : hcpd_top

// File: verif/hcpd_checker.sv
/* Port-timing checker of the header check and delineation block.
   Assumes one clock and the asynchronous active-high reset of the top. */
module hcpd_checker (
    // clock, reset and attachment side
    input wire logic                        i_sys_clk,
    input wire logic                        i_rst,
    input wire logic                        i_tx_octet_rdy,
    input wire logic [hcpd_pkg::OCT_W-1:0]  o_tx_octet,
    input wire logic                        i_rx_octet_en,
    // mac side
    input wire logic [hcpd_pkg::WORD_W-1:0] o_rx_word,
    input wire logic [hcpd_pkg::CTRL_W-1:0] o_rx_ctrl,
    input wire logic                        o_rx_start,
    input wire logic                        o_rx_locked
);
    import hcpd_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence s_hdr; (o_rx_ctrl == 4'h0) [*2]; endsequence
    property p_hold; !i_tx_octet_rdy |=> $stable(o_tx_octet); endproperty
    a_hold: assert property (p_hold) else $error("octet changed untaken");
    property p_one; o_rx_start |=> !o_rx_start; endproperty
    a_one: assert property (p_one) else $error("start not a pulse");
    property p_slk; o_rx_start |-> o_rx_locked; endproperty
    a_slk: assert property (p_slk) else $error("start while unlocked");
    property p_en; o_rx_start |-> $past(i_rx_octet_en); endproperty
    a_en: assert property (p_en) else $error("start without octet");
    property p_hdr; o_rx_start |=> s_hdr; endproperty
    a_hdr: assert property (p_hdr) else $error("header words not data");
    property p_null; o_rx_ctrl == 4'hF |-> o_rx_word == {4{NULL_CHAR}}; endproperty
    a_null: assert property (p_null) else $error("null word wrong");
    property p_conf; $rose(o_rx_locked) |-> !o_rx_start && $past(i_rx_octet_en); endproperty
    a_conf: assert property (p_conf) else $error("lock entry wrong");
    property p_lost; $fell(o_rx_locked) |-> $past(i_rx_octet_en); endproperty
    a_lost: assert property (p_lost) else $error("lock lost without octet");
endmodule : hcpd_checker
bind hcpd_top hcpd_checker u_hcpd_checker (.*);

// File: verif/hcpd_pma_model.sv
/* Attachment-layer model: takes transmit octets with stalls and loops them
   back into receive with gaps. Assumes the bench reads its octet log. */
module hcpd_pma_model (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst,
    input  wire logic [hcpd_pkg::OCT_W-1:0] i_tx_octet,
    output logic                            o_tx_octet_rdy,
    output logic      [hcpd_pkg::OCT_W-1:0] o_rx_octet,
    output logic                            o_rx_octet_en
);
    timeunit 1ns;
    timeprecision 1ns;
    import hcpd_pkg::*;
    logic [7:0] got[$];
    int         n = 0;
    int         rd = 0;
    initial {o_tx_octet_rdy, o_rx_octet_en, o_rx_octet} = '0;
    // overhead slots every fifth and seventh cycle stall each direction
    always @(posedge i_sys_clk) begin
        if (!i_rst && o_tx_octet_rdy) got.push_back(i_tx_octet);
        if (o_rx_octet_en) rd = rd + 1;
        n = n + 1;
        o_tx_octet_rdy <= (n % 5 != 0);
        o_rx_octet_en <= (n % 7 != 0) && rd < got.size();
        // one bit of the fourth header is flipped
        o_rx_octet <= (n % 7 != 0 && rd < got.size()) ? got[rd] ^ 8'(rd == 99) : ~o_rx_octet;
    end
endmodule : hcpd_pma_model

// File: verif/hcpd_top_tb_top.sv
/* Bench: idle fill, check field, lock and start flagging through loopback.
   Assumes the attachment model returns every octet it takes. */
module hcpd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hcpd_pkg::*;
    `define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
        $display("wrong value %s exp %h seen %h", n, e, a); end end
    logic       clk = 1'b0, rst = 1'b1, tv = 1'b0, tl = 1'b0, rdy, ordy, ren, start, lk;
    logic [7:0] td = 8'h00, tx, rx;
    logic [31:0] wd, hw;
    logic [3:0] ct, hc;
    logic       pend = 1'b0;
    int         error_cnt = 0, n_compared = 0, n_start = 0, n_full = 0;
    hcpd_top u_hcpd_top (.i_sys_clk(clk), .i_rst(rst), .i_tx_valid(tv), .i_tx_data(td),
        .i_tx_last(tl), .o_tx_ready(rdy), .o_tx_octet(tx), .i_tx_octet_rdy(ordy),
        .i_rx_octet(rx), .i_rx_octet_en(ren), .o_rx_word(wd), .o_rx_ctrl(ct),
        .o_rx_start(start), .o_rx_locked(lk));
    hcpd_pma_model u_hcpd_pma_model (.i_sys_clk(clk), .i_rst(rst), .i_tx_octet(tx),
        .o_tx_octet_rdy(ordy), .o_rx_octet(rx), .o_rx_octet_en(ren));
    always @(posedge clk) begin
        if (pend) {hw, hc} = {wd, ct};
        pend = start && n_start == 0;
        n_start += start;
        n_full += !rdy;
    end
    function automatic logic [15:0] exp_hec(input logic [63:0] h);
        logic [15:0] c = 16'h0000;
        for (int i = 0; i < 64; i++)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ h[i]) ? 16'h1021 : 16'h0000);
        return c ^ 16'h1555;
    endfunction : exp_hec
    task automatic t_idle();
        for (int k = 0; k < 200 && u_hcpd_pma_model.got.size() < 9; k++) @(negedge clk);
        for (int i = 0; i < 9; i++) `CHK("idle", IDLE_SEQ[71-8*i -: 8], u_hcpd_pma_model.got[i])
        `CHK("locked", 1'b0, lk)
        $display("test idle done");
    endtask : t_idle
    // four packets back to back: search, confirm, then two flagged starts
    task automatic t_pkt();
        logic [7:0]  p[$] = '{8'h00, 8'h10, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hD5};
        logic [15:0] e = exp_hec(64'hD555_5555_5555_1000);
        logic [7:0]  e_hi, e_lo;
        int          k = 0;
        e_hi = {<<{e[15:8]}};
        e_lo = {<<{e[7:0]}};
        for (int i = 0; i < 16; i++) p.push_back(8'(i * 3 + 1));
        repeat (4) foreach (p[i]) begin
            {tv, td, tl} = {1'b1, p[i], i == 23};
            while (!rdy) @(negedge clk);
            @(negedge clk);
        end
        {tv, tl} = 2'b00;
        repeat (300) @(negedge clk);
        while (k < 400 && !(u_hcpd_pma_model.got[k] == 8'h00
               && u_hcpd_pma_model.got[k+1] == 8'h10)) k++;
        `CHK("hec_hi", e_hi, u_hcpd_pma_model.got[k+8])
        `CHK("hec_lo", e_lo, u_hcpd_pma_model.got[k+9])
        `CHK("starts", 2, n_start)
        `CHK("hdr_word", 32'h5555_1000, hw)
        `CHK("hdr_ctrl", 4'h0, hc)
        `CHK("fifo_full", 1'b1, n_full > 0)
        $display("test packets done");
    endtask : t_pkt
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial forever #25 clk = ~clk;
    initial begin
        #(50 * 5000);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_idle();
        t_pkt();
        final_report();
    end
endmodule : hcpd_top_tb_top
